// *** shared/dqpa_params.svh ***
/*
  timing counts, field positions and sizes for the dma queue/port arbitration core.
  assumes inclusion by bare name from the package and design files.
*/
`ifndef DQPA_PARAMS_SVH
`define DQPA_PARAMS_SVH
`define DQPA_NUM_PRI 4
`define DQPA_NUM_REQ 3
`define DQPA_QUEUE_DEPTH 16
`define DQPA_CNT_W 5
`define DQPA_REQ_CHAN 0
`define DQPA_REQ_L2 1
`define DQPA_REQ_MPER 2
`define DQPA_NUM_CHAN 8
`define DQPA_RD_WORDS 2
`define DQPA_WR_WORDS 32
`define DQPA_RDS_PER_WR 16
`define DQPA_WR_BUFS 4
`define DQPA_PRI_URGENT 2'h0
`define DQPA_PRI_MEDIUM 2'h2
`define DQPA_XFER_W 16
`endif

// *** shared/dqpa_pkg.sv ***
/*
  types for the dma queue/port arbitration core.
  assumes dqpa_params.svh on the include path.
*/
`include "dqpa_params.svh"
package dqpa_pkg;
  typedef logic [1:0] dqpa_pri_t; // priority level, 0 is urgent
  typedef enum logic [1:0] {
    DQPA_IDLE = 2'b00, // queue register set empty
    DQPA_RUN = 2'b01, // issuing commands
    DQPA_DONE = 2'b10 // last command sent
  } dqpa_qrs_t;
endpackage

// *** hdl/dqpa_port_buf.sv ***
/*
  command buffer of one peripheral port: strict arrival-order fifo.
  assumes the drain side executes the head command when exec_valid and exec_ready meet.
*/
`timescale 1ns/10ps
`include "dqpa_params.svh"
module dqpa_port_buf
  import dqpa_pkg::*;
#(
  parameter int DEPTH = `DQPA_WR_BUFS, // command slots
  parameter int WIDTH = 4 // bits per command
) (
  input wire logic clk, // engine clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic push, // new command
  input wire logic [WIDTH-1:0] push_cmd, // command word
  output logic full, // no free slot
  output logic exec_valid, // head command ready
  output logic [WIDTH-1:0] exec_cmd, // head command
  input wire logic exec_ready // port consumed head
);
  localparam int AW = $clog2(DEPTH);
  // pointer wrap bit only works for power-of-two depths
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH]; // command slots
  logic [AW:0] wp; // write pointer
  logic [AW:0] rp; // read pointer
  logic do_pop; // head leaves
  assign do_pop = exec_valid && exec_ready;
  assign full = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);
  assign exec_valid = wp != rp;
  assign exec_cmd = mem[rp[AW-1:0]];
  // arrival-order storage, no priority reordering
  always_ff @(posedge clk) begin
    if (rst) begin
      wp <= '0;
      rp <= '0;
    end else if (ce) begin
      if (push && !full) begin
        mem[wp[AW-1:0]] <= push_cmd;
        wp <= wp + 1'b1;
      end
      if (do_pop) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule // dqpa_port_buf

// *** hdl/dqpa_core.sv ***
/*
  transfer controller core: requestor admission with allotments and stalls,
  per-priority request fifos, one queue register set per level, priority
  arbitration of separate read and write pipelines onto port command buffers.
  assumes requests are single-cycle pulses from same-clock logic; events from pins are pre-synchronised elsewhere.
*/
`timescale 1ns/10ps
`include "dqpa_params.svh"
// Operation
// - level-two port reads move two words
// - external port writes once one buffer full
// - source may divert, destination keeps draining
// - higher priority set wins command submission
// - port finishes buffered commands before newer ones
// - external port holds four 32-word writes
// - one register set per level, waits
// - channel requestor stall blocks all events
// - level-two requestor stall holds all its submissions
// - medium stall releases when request enters set
// - stalled channel events kept once each
// - read and write pipelines run independently
// - each priority queue is first-in first-out
// - lower level number wins arbitration
// - at most sixteen requests per queue
// - arrival order, round-robin among simultaneous
// - zero allotment stalls forever
module dqpa_core
  import dqpa_pkg::*;
#(
  parameter int NPRI = `DQPA_NUM_PRI, // priority levels
  parameter int NREQ = `DQPA_NUM_REQ, // requestors
  parameter int QDEPTH = `DQPA_QUEUE_DEPTH, // queue entries
  parameter int NCHAN = `DQPA_NUM_CHAN, // event channels
  parameter int XW = `DQPA_XFER_W // write-command count width
) (
  input wire logic clk, // engine clock, 125 MHz
  input wire logic rst, // sync reset, active high
  input wire logic ce, // clock enable
  input wire logic [NCHAN-1:0] chan_event, // channel sync events, pulses
  input wire logic [NCHAN*2-1:0] chan_pri, // priority per channel
  input wire logic [NCHAN*XW-1:0] chan_len, // write commands per channel request
  input wire logic l2_req, // level-two requestor request
  input wire logic [1:0] l2_pri, // its priority
  input wire logic [XW-1:0] l2_len, // its length in write commands
  input wire logic mper_req, // master peripheral request
  input wire logic [1:0] mper_pri, // its priority
  input wire logic [XW-1:0] mper_len, // its length
  input wire logic [NREQ*NPRI*5-1:0] allot, // allotment per requestor per level
  input wire logic rd_exec_ready, // level-two port consumes read
  input wire logic wr_exec_ready, // external port consumes write
  output logic chan_stalled, // channel requestor stalled
  output logic l2_stalled, // level-two requestor stalled
  output logic [NPRI-1:0] qrs_busy, // register set busy per level
  output logic rd_exec_valid, // read command at port head
  output logic [1:0] rd_exec_pri, // its priority
  output logic wr_exec_valid, // write command at port head
  output logic [1:0] wr_exec_pri, // its priority
  output logic [NPRI-1:0] xfer_done // transfer finished pulse
);
  localparam int QAW = $clog2(QDEPTH);
  localparam int ENTW = XW + 2; // length plus requestor id
  // two-bit tags and pointer wrap bits fix these sizes
  if (NPRI != 4 || NREQ != 3 || QDEPTH < 2 || (QDEPTH & (QDEPTH - 1)) != 0) begin : g_bad_size
    $error("unsupported core parameters");
  end

  // decode a requestor's allotment for a level
  function automatic logic [4:0] allot_of(input logic [NREQ*NPRI*5-1:0] a, input int r, input int p);
    allot_of = a[(r*NPRI+p)*5 +: 5];
  endfunction

  logic [4:0] outst [NREQ][NPRI]; // outstanding counters
  logic [NCHAN-1:0] chan_pend; // events waiting in channel controller
  logic [1:0] rr; // round-robin pointer
  logic [NPRI-1:0] take; // set takes fifo head this cycle
  logic [1:0] take_req [NPRI]; // requestor id of taken head

  // channel requestor: pick lowest pending channel
  logic chan_any;
  logic [$clog2(NCHAN)-1:0] chan_sel;
  always_comb begin
    chan_any = 1'b0;
    chan_sel = '0;
    for (int c = NCHAN - 1; c >= 0; c--) begin
      if (chan_pend[c] || chan_event[c]) begin
        chan_any = 1'b1;
        chan_sel = c[$clog2(NCHAN)-1:0];
      end
    end
  end

  // candidate submissions per requestor
  logic [NREQ-1:0] cand;
  logic [1:0] cand_pri [NREQ];
  logic [XW-1:0] cand_len [NREQ];
  logic [NREQ-1:0] over; // would exceed allotment
  logic [2:1] raw; // live or held request per level-two and master peripheral requestor
  logic [2:1] held; // refused request kept for retry
  logic [1:0] held_pri [1:2]; // its priority
  logic [XW-1:0] held_len [1:2]; // its length
  always_comb begin
    cand[0] = chan_any && !chan_stalled;
    cand_pri[0] = chan_pri[chan_sel*2 +: 2];
    cand_len[0] = chan_len[chan_sel*XW +: XW];
    raw[1] = l2_req || held[1];
    raw[2] = mper_req || held[2];
    cand[1] = raw[1] && !l2_stalled;
    cand_pri[1] = held[1] ? held_pri[1] : l2_pri;
    cand_len[1] = held[1] ? held_len[1] : l2_len;
    cand[2] = raw[2];
    cand_pri[2] = held[2] ? held_pri[2] : mper_pri;
    cand_len[2] = held[2] ? held_len[2] : mper_len;
    for (int r = 0; r < NREQ; r++) begin
      over[r] = outst[r][cand_pri[r]] >= allot_of(allot, r, int'(cand_pri[r]));
    end
  end

  // one submission per cycle, round-robin among simultaneous
  logic sub_ok;
  logic [1:0] sub_r;
  always_comb begin
    sub_ok = 1'b0;
    sub_r = 2'd0;
    for (int k = NREQ - 1; k >= 0; k--) begin
      automatic int r = (int'(rr) + k) % NREQ;
      if (cand[r] && !over[r]) begin
        sub_ok = 1'b1;
        sub_r = r[1:0];
      end
    end
  end

  // priority request fifos
  logic [ENTW-1:0] qmem [NPRI][QDEPTH];
  logic [QAW:0] qwp [NPRI];
  logic [QAW:0] qrp [NPRI];
  logic [NPRI-1:0] qempty;
  logic [NPRI-1:0] qfull;
  logic sub_fire; // submission really accepted
  assign sub_fire = sub_ok && !qfull[cand_pri[sub_r]];

  // requestors only pulse, so a request that loses round-robin or meets a stall is kept here
  always_ff @(posedge clk) begin
    if (rst) begin
      held <= '0;
      for (int r = 1; r < NREQ; r++) begin
        held_pri[r] <= 2'd0;
        held_len[r] <= '0;
      end
    end else if (ce) begin
      for (int r = 1; r < NREQ; r++) begin
        held[r] <= raw[r] && !(sub_fire && sub_r == r[1:0]);
        if (!held[r]) begin
          held_pri[r] <= cand_pri[r];
          held_len[r] <= cand_len[r];
        end
      end
    end
  end

  genvar gp;
  generate
    for (gp = 0; gp < NPRI; gp++) begin : g_q
      assign qempty[gp] = qwp[gp] == qrp[gp];
      assign qfull[gp] = (qwp[gp][QAW] != qrp[gp][QAW]) && (qwp[gp][QAW-1:0] == qrp[gp][QAW-1:0]);
      assign take_req[gp] = qmem[gp][qrp[gp][QAW-1:0]][ENTW-1 -: 2];
      // fifo write/read per level
      always_ff @(posedge clk) begin
        if (rst) begin
          qwp[gp] <= '0;
          qrp[gp] <= '0;
        end else if (ce) begin
          if (sub_fire && cand_pri[sub_r] == 2'(gp)) begin
            qmem[gp][qwp[gp][QAW-1:0]] <= {sub_r, cand_len[sub_r]};
            qwp[gp] <= qwp[gp] + 1'b1;
          end
          if (take[gp]) begin
            qrp[gp] <= qrp[gp] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // outstanding counters: up on submit, down when head enters set
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int r = 0; r < NREQ; r++) begin
        for (int p = 0; p < NPRI; p++) outst[r][p] <= '0;
      end
    end else if (ce) begin
      for (int r = 0; r < NREQ; r++) begin
        for (int p = 0; p < NPRI; p++) begin
          outst[r][p] <= outst[r][p] + 5'((sub_fire && sub_r == r[1:0] && cand_pri[r] == p[1:0]) ? 1 : 0)
            - 5'((take[p] && take_req[p] == r[1:0]) ? 1 : 0);
        end
      end
    end
  end

  // stall flags: set on over-allotment, cleared when the stalled requestor's own head at that level enters a set
  logic [1:0] chan_stall_pri;
  logic [1:0] l2_stall_pri;
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_stalled <= 1'b0;
      l2_stalled <= 1'b0;
      chan_stall_pri <= 2'd0;
      l2_stall_pri <= 2'd0;
      rr <= 2'd0;
    end else if (ce) begin
      if (chan_stalled && take[chan_stall_pri] && take_req[chan_stall_pri] == 2'(`DQPA_REQ_CHAN)) begin
        chan_stalled <= 1'b0;
      end else if (cand[0] && over[0] && !(take[cand_pri[0]] && take_req[cand_pri[0]] == 2'(`DQPA_REQ_CHAN))) begin
        // a head of ours entering its set this cycle frees the slot, so no stall then
        chan_stalled <= 1'b1;
        chan_stall_pri <= cand_pri[0];
      end
      if (l2_stalled && take[l2_stall_pri] && take_req[l2_stall_pri] == 2'(`DQPA_REQ_L2)) begin
        l2_stalled <= 1'b0;
      end else if (cand[1] && over[1] && !(take[cand_pri[1]] && take_req[cand_pri[1]] == 2'(`DQPA_REQ_L2))) begin
        l2_stalled <= 1'b1;
        l2_stall_pri <= cand_pri[1];
      end
      if (sub_fire) rr <= (sub_r == 2'(NREQ - 1)) ? 2'd0 : sub_r + 2'd1;
    end
  end

  // channel event latch: first event kept, repeats merge
  always_ff @(posedge clk) begin
    if (rst) begin
      chan_pend <= '0;
    end else if (ce) begin
      for (int c = 0; c < NCHAN; c++) begin
        // a submitted channel keeps only an event that came on top of a pending one
        if (sub_fire && sub_r == 2'(`DQPA_REQ_CHAN) && chan_sel == c[$clog2(NCHAN)-1:0]) begin
          chan_pend[c] <= chan_pend[c] && chan_event[c];
        end else if (chan_event[c]) begin
          chan_pend[c] <= 1'b1;
        end
      end
    end
  end

  // queue register sets, one per level
  dqpa_qrs_t qstate [NPRI];
  logic [XW-1:0] wr_left [NPRI]; // write commands to go
  logic [4:0] rd_left [NPRI]; // reload-only, nonzero while another write still needs reads
  logic [4:0] rd_fill [NPRI]; // reads done toward next write
  logic [2:0] wr_ahead [NPRI]; // filled write buffers not yet issued
  logic [NPRI-1:0] rd_want; // set wants a read slot
  logic [NPRI-1:0] wr_want; // set wants a write slot
  logic [NPRI-1:0] rd_gnt;
  logic [NPRI-1:0] wr_gnt;
  logic rd_full;
  logic wr_full;

  // fixed priority pick, level 0 first
  function automatic logic [NPRI-1:0] pick(input logic [NPRI-1:0] w);
    pick = w & ~(w - 1'b1);
  endfunction

  always_comb begin
    for (int p = 0; p < NPRI; p++) begin
      take[p] = (qstate[p] == DQPA_IDLE) && !qempty[p];
      rd_want[p] = (qstate[p] == DQPA_RUN) && (rd_left[p] != 5'd0) && (wr_ahead[p] < 3'(`DQPA_WR_BUFS));
      wr_want[p] = (qstate[p] == DQPA_RUN) && (wr_ahead[p] != 3'd0);
    end
    rd_gnt = rd_full ? '0 : pick(rd_want);
    wr_gnt = wr_full ? '0 : pick(wr_want);
  end

  generate
    for (gp = 0; gp < NPRI; gp++) begin : g_set
      // per-level transfer sequencing
      always_ff @(posedge clk) begin
        if (rst) begin
          qstate[gp] <= DQPA_IDLE;
          wr_left[gp] <= '0;
          rd_left[gp] <= '0;
          rd_fill[gp] <= '0;
          wr_ahead[gp] <= '0;
          xfer_done[gp] <= 1'b0;
        end else if (ce) begin
          xfer_done[gp] <= 1'b0;
          case (qstate[gp])
            DQPA_IDLE: begin
              if (take[gp]) begin
                qstate[gp] <= DQPA_RUN;
                wr_left[gp] <= qmem[gp][qrp[gp][QAW-1:0]][XW-1:0];
                rd_left[gp] <= (qmem[gp][qrp[gp][QAW-1:0]][XW-1:0] == '0) ? 5'd0 : 5'(`DQPA_RDS_PER_WR);
                rd_fill[gp] <= '0;
                wr_ahead[gp] <= '0;
              end
            end
            DQPA_RUN: begin
              if (rd_gnt[gp]) begin
                // sixteen two-word reads fill one write
                if (rd_fill[gp] == 5'(`DQPA_RDS_PER_WR - 1)) rd_fill[gp] <= '0;
                else rd_fill[gp] <= rd_fill[gp] + 5'd1;
              end
              wr_ahead[gp] <= wr_ahead[gp] + 3'((rd_gnt[gp] && rd_fill[gp] == 5'(`DQPA_RDS_PER_WR - 1)) ? 1 : 0)
                - 3'(wr_gnt[gp] ? 1 : 0);
              if (rd_gnt[gp] && rd_fill[gp] == 5'(`DQPA_RDS_PER_WR - 1)) begin
                rd_left[gp] <= (wr_left[gp] > XW'(wr_ahead[gp]) + XW'(1)) ? 5'(`DQPA_RDS_PER_WR) : 5'd0;
              end
              if (wr_gnt[gp]) begin
                wr_left[gp] <= wr_left[gp] - 1'b1;
                if (wr_left[gp] == XW'(1)) qstate[gp] <= DQPA_DONE;
              end
              if (wr_left[gp] == '0) qstate[gp] <= DQPA_DONE;
            end
            DQPA_DONE: begin
              qstate[gp] <= DQPA_IDLE;
              xfer_done[gp] <= 1'b1;
            end
            default: qstate[gp] <= DQPA_IDLE;
          endcase
        end
      end
    end
  endgenerate

  // busy status per set
  always_ff @(posedge clk) begin
    if (rst) qrs_busy <= '0;
    else if (ce) begin
      for (int p = 0; p < NPRI; p++) qrs_busy[p] <= take[p] || (qstate[p] == DQPA_RUN);
    end
  end

  // encode granted level as command tag
  function automatic logic [1:0] enc(input logic [NPRI-1:0] g);
    enc = 2'd0;
    for (int p = NPRI - 1; p >= 0; p--) if (g[p]) enc = p[1:0];
  endfunction

  logic rd_hv;
  logic [1:0] rd_hc;
  logic wr_hv;
  logic [1:0] wr_hc;
  // level-two read command buffer
  dqpa_port_buf #(.DEPTH(8), .WIDTH(2)) u_rd_port (
    .clk(clk), .rst(rst), .ce(ce), .push(|rd_gnt), .push_cmd(enc(rd_gnt)), .full(rd_full),
    .exec_valid(rd_hv), .exec_cmd(rd_hc), .exec_ready(rd_exec_ready)
  );
  // external memory write command buffer
  dqpa_port_buf #(.DEPTH(`DQPA_WR_BUFS), .WIDTH(2)) u_wr_port (
    .clk(clk), .rst(rst), .ce(ce), .push(|wr_gnt), .push_cmd(enc(wr_gnt)), .full(wr_full),
    .exec_valid(wr_hv), .exec_cmd(wr_hc), .exec_ready(wr_exec_ready)
  );

  // registered head view toward the ports
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_exec_valid <= 1'b0;
      rd_exec_pri <= 2'd0;
      wr_exec_valid <= 1'b0;
      wr_exec_pri <= 2'd0;
    end else if (ce) begin
      rd_exec_valid <= rd_hv;
      rd_exec_pri <= rd_hc;
      wr_exec_valid <= wr_hv;
      wr_exec_pri <= wr_hc;
    end
  end
endmodule // dqpa_core

// *** verification/dqpa_core_asserts.sv ***
/*
  checker for the port-level behaviour of dqpa_core.
  assumes it is bound to every dqpa_core instance.
*/
`timescale 1ns/10ps
module dqpa_core_asserts #(
  parameter int NPRI = 4 // priority levels
) (
  input wire logic clk, // engine clock
  input wire logic rst, // sync reset
  input wire logic ce, // clock enable
  input wire logic l2_req, // level-two request
  input wire logic rd_exec_ready, // read port pop
  input wire logic wr_exec_ready, // write port pop
  input wire logic chan_stalled, // channel stall flag
  input wire logic l2_stalled, // level-two stall flag
  input wire logic [NPRI-1:0] qrs_busy, // register sets busy
  input wire logic rd_exec_valid, // read head shown
  input wire logic [1:0] rd_exec_pri, // its priority
  input wire logic wr_exec_valid, // write head shown
  input wire logic [1:0] wr_exec_pri, // its priority
  input wire logic [NPRI-1:0] xfer_done // done pulses
);
  int rd_n; // reads consumed
  int wr_n; // writes consumed
  // count commands the ports take
  always_ff @(posedge clk) begin
    if (rst) begin
      rd_n <= 0;
      wr_n <= 0;
    end else if (ce) begin
      rd_n <= rd_n + int'(rd_exec_ready && rd_exec_valid);
      wr_n <= wr_n + int'(wr_exec_ready && wr_exec_valid);
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_reset_quiet: assert property ($past(rst) |-> qrs_busy == '0 && !l2_stalled && !chan_stalled)
    else $error("state not cleared by reset");
  a_done_pulse: assert property (ce && (|xfer_done) |=> (xfer_done & $past(xfer_done)) == '0)
    else $error("done pulse longer than one cycle");
  a_done_busy: assert property ((|xfer_done) |-> (xfer_done & ~$past(qrs_busy)) == '0)
    else $error("done on a level that was not busy");
  a_rd_hold: assert property (!rd_exec_ready ##1 (!rd_exec_ready && rd_exec_valid)
    |=> rd_exec_valid && $stable(rd_exec_pri))
    else $error("read head changed without a pop");
  a_wr_hold: assert property (!wr_exec_ready ##1 (!wr_exec_ready && wr_exec_valid)
    |=> wr_exec_valid && $stable(wr_exec_pri))
    else $error("write head changed without a pop");
  a_rd_wr_ratio: assert property (wr_n * 16 <= rd_n + 16)
    else $error("write executed before its reads");
  a_l2_stall_cause: assert property ($rose(l2_stalled) |-> $past(l2_req))
    else $error("level-two stall without a request");
  a_ce_freeze: assert property (!ce |=> $stable(qrs_busy) && $stable(l2_stalled) && $stable(chan_stalled))
    else $error("state moved while clock enable low");
  a_cmd_needs_set: assert property ($rose(rd_exec_valid) || $rose(wr_exec_valid)
    |-> (|$past(qrs_busy)) || (|$past(qrs_busy, 2)) || (|$past(qrs_busy, 3)))
    else $error("command appeared with no active set");
endmodule // dqpa_core_asserts

bind dqpa_core dqpa_core_asserts #(.NPRI(NPRI)) u_chk (.clk(clk), .rst(rst), .ce(ce), .l2_req(l2_req),
  .rd_exec_ready(rd_exec_ready), .wr_exec_ready(wr_exec_ready), .chan_stalled(chan_stalled),
  .l2_stalled(l2_stalled), .qrs_busy(qrs_busy), .rd_exec_valid(rd_exec_valid), .rd_exec_pri(rd_exec_pri),
  .wr_exec_valid(wr_exec_valid), .wr_exec_pri(wr_exec_pri), .xfer_done(xfer_done));

// *** verification/dqpa_port_model.sv ***
/*
  peripheral port model: takes head commands in arrival order, at random pace.
  assumes valid is the core's registered head flag, one cycle behind its fifo.
*/
`timescale 1ns/10ps
module dqpa_port_model (
  input wire logic clk, // engine clock
  input wire logic rst, // sync reset
  input wire logic ce, // core clock enable
  input wire logic slow, // hold the port off
  input wire logic valid, // head command shown
  output logic ready, // consume head
  output int count // commands executed
);
  logic rdy_d; // ready one cycle back
  // valid lags the fifo, so it is trusted only two cycles after the last pop
  always_ff @(posedge clk) begin
    if (rst) begin
      ready <= 1'b0;
      rdy_d <= 1'b0;
      count <= 0;
    end else begin
      rdy_d <= ready;
      ready <= valid && !ready && !rdy_d && !slow && ($urandom_range(1) == 1);
      if (ready && ce) count <= count + 1;
    end
  end
endmodule // dqpa_port_model

// *** verification/tb.sv ***
/*
  bench for dqpa_core: requestor stimulus and port models on both pipelines.
  assumes the checker and port model compiled before it.
*/
`timescale 1ns/10ps
`include "dqpa_params.svh"
module tb;
  logic clk, rst, ce, l2_req, mper_req, slow, rd_rdy, wr_rdy; // controls
  logic [7:0] chan_event; // channel events
  logic [15:0] chan_pri, l2_len, mper_len; // attributes
  logic [127:0] chan_len; // channel lengths
  logic [1:0] l2_pri, mper_pri, rd_p, wr_p; // priorities
  logic [59:0] allot, a; // allotments
  logic chan_stalled, l2_stalled, rd_v, wr_v; // status
  logic [3:0] qrs_busy, xfer_done; // per level
  int rd_n, wr_n, errors, compares, w, dn; // counts
  logic l2_seen, ch_seen; // stall seen
  dqpa_core uut (.clk(clk), .rst(rst), .ce(ce), .chan_event(chan_event), .chan_pri(chan_pri),
    .chan_len(chan_len), .l2_req(l2_req), .l2_pri(l2_pri), .l2_len(l2_len), .mper_req(mper_req),
    .mper_pri(mper_pri), .mper_len(mper_len), .allot(allot), .rd_exec_ready(rd_rdy), .wr_exec_ready(wr_rdy),
    .chan_stalled(chan_stalled), .l2_stalled(l2_stalled), .qrs_busy(qrs_busy), .rd_exec_valid(rd_v),
    .rd_exec_pri(rd_p), .wr_exec_valid(wr_v), .wr_exec_pri(wr_p), .xfer_done(xfer_done));
  dqpa_port_model u_rd (.clk(clk), .rst(rst), .ce(ce), .slow(1'b0), .valid(rd_v), .ready(rd_rdy), .count(rd_n));
  dqpa_port_model u_wr (.clk(clk), .rst(rst), .ce(ce), .slow(slow), .valid(wr_v), .ready(wr_rdy), .count(wr_n));
  // done pulses and stall flags seen
  always @(posedge clk) begin
    dn <= rst ? 0 : dn + $countones(xfer_done & {4{ce}});
    l2_seen <= !rst && (l2_seen || l2_stalled);
    ch_seen <= !rst && (ch_seen || chan_stalled);
  end
  function automatic int exp_reads(int wcmd);
    return wcmd * `DQPA_RDS_PER_WR;
  endfunction
  task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %0d seen %0d", nm, exp, got);
    end
  endtask
  task automatic reset_dut(logic [59:0] al);
    @(posedge clk);
    rst <= 1'b1;
    ce <= 1'b1;
    allot <= al;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
  endtask
  task automatic l2_send(logic [1:0] p, logic [15:0] n);
    @(negedge clk);
    for (int k = 0; k < 500 && l2_stalled !== 1'b0; k++) @(negedge clk);
    @(posedge clk);
    l2_req <= 1'b1;
    l2_pri <= p;
    l2_len <= n;
    @(posedge clk);
    l2_req <= 1'b0;
  endtask
  task automatic wait_quiet(string nm, int wcmd, int ndone);
    int q;
    q = 0;
    for (int k = 0; k < 4000 && q < 30; k++) begin
      @(negedge clk);
      q = (qrs_busy === 4'h0 && rd_v === 1'b0 && wr_v === 1'b0) ? q + 1 : 0;
    end
    chk("quiet", 30, q);
    chk("reads", exp_reads(wcmd), rd_n);
    chk("writes", wcmd, wr_n);
    chk("done", ndone, dn);
    $display("test %s ended", nm);
  endtask
  task automatic end_sim();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // engine clock
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // hang cutter
  initial begin
    #400000;
    errors++;
    end_sim();
  end
  initial begin
    {rst, ce, l2_req, mper_req, slow, chan_event, l2_pri, l2_len, mper_pri, mper_len} = '0;
    rst = 1'b1;
    chan_pri = {4'h1, 12'h555};
    chan_len = {8{16'h0001}};
    allot = '0;
    void'($urandom(32'hb041));
    // random pairs of simultaneous requests, with a clock-enable freeze
    reset_dut({12{5'h0f}});
    w = 0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      {l2_req, mper_req} <= 2'b11;
      l2_pri <= 2'($urandom_range(3));
      mper_pri <= 2'($urandom_range(3));
      l2_len <= 16'($urandom_range(1, 2));
      mper_len <= 16'($urandom_range(1, 2));
      @(posedge clk);
      {l2_req, mper_req} <= 2'b00;
      w += int'(l2_len) + int'(mper_len);
      repeat (2) @(posedge clk);
    end
    ce <= 1'b0;
    repeat (6) @(posedge clk);
    ce <= 1'b1;
    wait_quiet("random", w, 12);
    // level-two requestor over its medium allotment, write port held
    a = {12{5'h0f}};
    a[30 +: 5] = 5'h01;
    reset_dut(a);
    slow <= 1'b1;
    l2_send(2'h2, 16'h0002);
    repeat (4) @(posedge clk);
    l2_send(2'h2, 16'h0002);
    l2_send(2'h2, 16'h0002);
    repeat (20) @(posedge clk);
    slow <= 1'b0;
    wait_quiet("l2_stall", 6, 3);
    chk("l2_stall", 1, l2_seen);
    // channel stall: events coalesce, urgent event waits
    a = {12{5'h0f}};
    a[5 +: 5] = 5'h01;
    reset_dut(a);
    @(posedge clk);
    chan_event <= 8'h07;
    @(posedge clk);
    chan_event <= 8'h00;
    for (int k = 0; k < 200 && chan_stalled !== 1'b1; k++) @(negedge clk);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      chan_event <= (i == 0) ? 8'h8a : 8'h02;
      @(posedge clk);
      chan_event <= 8'h00;
    end
    @(negedge clk);
    chk("stall_held", 1, chan_stalled);
    chk("urgent_busy", 0, qrs_busy[0]);
    wait_quiet("chan_stall", 6, 6);
    chk("chan_stall", 1, ch_seen);
    // zero allotment on the low level never releases
    a = {12{5'h0f}};
    a[35 +: 5] = 5'h00;
    reset_dut(a);
    l2_send(2'h3, 16'h0001);
    repeat (100) @(posedge clk);
    @(negedge clk);
    chk("zero_stall", 1, l2_stalled);
    chk("zero_busy", 0, qrs_busy[3]);
    $display("test zero_allot ended");
    reset_dut({12{5'h0f}});
    end_sim();
  end
endmodule // tb
